// ---- src/gpio_ports.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "gpio_defines.svh"
module gpio_ports
   import gpio_pkg::*;
#(
   parameter bit HAS_PORT_C = 1'b1
) (
   input wire logic SYS_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic CLK_EN_I,
   input wire mem_req_t MEM_REQ_I,
   output logic MEM_HIT_O,
   output logic [7:0] MEM_RDATA_O,
   output logic MEM_RVALID_O,
   input wire pctl_req_t PCTL_REQ_I,
   output logic [7:0] PCTL_RDATA_O,
   output logic PCTL_RVALID_O,
   input wire logic SEL_WR_I,
   input wire logic [7:0] SEL_WDATA_I,
   output logic [7:0] SEL_O,
   input wire logic [3:0] PA_PIN_I,
   output logic [3:0] PA_PIN_O,
   output logic [3:0] PA_PIN_OE_N_O,
   input wire logic [7:0] PB_PIN_I,
   output logic [7:0] PB_PIN_O,
   output logic [7:0] PB_PIN_OE_N_O,
   input wire logic [7:0] PC_PIN_I,
   output logic [7:0] PC_PIN_O,
   output logic [7:0] PC_PIN_OE_N_O,
   output pin_cfg_t PA_CFG_O,
   output pin_cfg_t PB_CFG_O,
   output pin_cfg_t PC_CFG_O,
   output logic [7:0] WAKE_PENDING_O,
   input wire logic CMP_RESULT_I,
   output logic [7:0] CMP_CTRL_O
);

   // ****************************************
   // Decode helpers
   // ****************************************

   // Whether a port has a register at this selector value
   function automatic logic names_reg(input logic [1:0] port, input logic [7:0] sel);
      logic hit;
      hit = 1'b0;
      case (port)
         `PORT_CODE_A: hit = (sel == `SEL_DIR) || (sel == `SEL_PULLUP)
                             || (sel == `SEL_LEVEL);
         `PORT_CODE_B: hit = (sel >= `SEL_CMP) && (sel <= `SEL_DIR);
         `PORT_CODE_C: hit = HAS_PORT_C && (sel >= `SEL_SCHMITT) && (sel <= `SEL_DIR);
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Whether a file address is one of the pin data registers
   function automatic logic addr_hit(input logic [7:0] addr);
      return (addr == `ADDR_PORT_A) || (addr == `ADDR_PORT_B)
             || (HAS_PORT_C && (addr == `ADDR_PORT_C));
   endfunction

   // ****************************************
   // Declarations
   // ****************************************
   logic [7:0] sel_r, sel_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [7:0] xdata_r, xdata_nxt;
   logic xvalid_r, xvalid_nxt;
   logic [7:0] cmp_r, cmp_nxt;
   logic pctl_ok;
   logic data_wr_a, data_wr_b, data_wr_c;
   logic ctl_wr_a, ctl_wr_b, ctl_wr_c;
   pin_cfg_t cfg_a, cfg_b, cfg_c;
   logic [7:0] latch_a, latch_b, latch_c;
   logic [7:0] pend_b;
   logic rst_seen_r;

   // ****************************************
   // Write strobes
   // ****************************************

   // Control writes pass only when the selector names a register
   assign pctl_ok = CLK_EN_I && PCTL_REQ_I.wr && names_reg(PCTL_REQ_I.port, sel_r);
   assign ctl_wr_a = pctl_ok && (PCTL_REQ_I.port == `PORT_CODE_A);
   assign ctl_wr_b = pctl_ok && (PCTL_REQ_I.port == `PORT_CODE_B);
   assign ctl_wr_c = pctl_ok && (PCTL_REQ_I.port == `PORT_CODE_C);

   // Data-memory writes to the pin latches
   assign data_wr_a = CLK_EN_I && MEM_REQ_I.wr && (MEM_REQ_I.addr == `ADDR_PORT_A);
   assign data_wr_b = CLK_EN_I && MEM_REQ_I.wr && (MEM_REQ_I.addr == `ADDR_PORT_B);
   assign data_wr_c = CLK_EN_I && MEM_REQ_I.wr && HAS_PORT_C
                      && (MEM_REQ_I.addr == `ADDR_PORT_C);

   // ****************************************
   // Port register banks
   // ****************************************

   // Four-pin port
   port_bank #(
      .WIDTH(4)
   ) u_bank_a (
      .clk_i(SYS_CLK_I),
      .rst_i(SYS_RST_I),
      .data_wr_i(data_wr_a),
      .ctl_wr_i(ctl_wr_a),
      .sel_i(sel_r),
      .wdata_i(ctl_wr_a ? PCTL_REQ_I.data : MEM_REQ_I.data),
      .cfg_o(cfg_a),
      .latch_o(latch_a)
   );

   // Eight-pin port with wakeup and comparator sharing
   port_bank #(
      .WIDTH(8)
   ) u_bank_b (
      .clk_i(SYS_CLK_I),
      .rst_i(SYS_RST_I),
      .data_wr_i(data_wr_b),
      .ctl_wr_i(ctl_wr_b),
      .sel_i(sel_r),
      .wdata_i(ctl_wr_b ? PCTL_REQ_I.data : MEM_REQ_I.data),
      .cfg_o(cfg_b),
      .latch_o(latch_b)
   );

   // Optional eight-pin port
   port_bank #(
      .WIDTH(8)
   ) u_bank_c (
      .clk_i(SYS_CLK_I),
      .rst_i(SYS_RST_I),
      .data_wr_i(data_wr_c),
      .ctl_wr_i(ctl_wr_c),
      .sel_i(sel_r),
      .wdata_i(ctl_wr_c ? PCTL_REQ_I.data : MEM_REQ_I.data),
      .cfg_o(cfg_c),
      .latch_o(latch_c)
   );

   // Wakeup edge capture on Port B
   wake_detect u_wake (
      .clk_i(SYS_CLK_I),
      .rst_i(SYS_RST_I),
      .ce_i(CLK_EN_I),
      .pins_i(PB_PIN_I),
      .ctl_wr_i(ctl_wr_b),
      .sel_i(sel_r),
      .wdata_i(PCTL_REQ_I.data),
      .pend_o(pend_b)
   );

   // ****************************************
   // Selector register
   // ****************************************

   // Loaded only by the dedicated selector write
   always_comb begin
      sel_nxt = sel_r;
      if (CLK_EN_I && SEL_WR_I) begin
         sel_nxt = SEL_WDATA_I;
      end
   end

   always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         sel_r <= `SEL_RESET;
      end else begin
         sel_r <= sel_nxt;
      end
   end

   // ****************************************
   // Data read path
   // ****************************************

   // Reads return the pins themselves
   always_comb begin
      rdata_nxt = rdata_r;
      rvalid_nxt = rvalid_r;
      if (CLK_EN_I) begin
         rvalid_nxt = MEM_REQ_I.rd && addr_hit(MEM_REQ_I.addr);
         if (rvalid_nxt) begin
            case (MEM_REQ_I.addr)
               `ADDR_PORT_A: rdata_nxt = {`PORT_A_PAD, PA_PIN_I};
               `ADDR_PORT_B: rdata_nxt = PB_PIN_I;
               default: rdata_nxt = PC_PIN_I;
            endcase
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         rdata_r <= `LATCH_RESET;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // ****************************************
   // Exchange path and comparator register
   // ****************************************

   // Pending accesses return the old contents; comparator accesses return old bits 7:1 with CMP_RESULT_I in bit 0
   always_comb begin
      xdata_nxt = xdata_r;
      xvalid_nxt = xvalid_r;
      cmp_nxt = cmp_r;
      if (CLK_EN_I) begin
         xvalid_nxt = 1'b0;
         if (ctl_wr_b && (sel_r == `SEL_WAKE_PEND)) begin
            xdata_nxt = pend_b;
            xvalid_nxt = 1'b1;
         end
         if (ctl_wr_b && (sel_r == `SEL_CMP)) begin
            xdata_nxt = {cmp_r[7:1], CMP_RESULT_I};
            xvalid_nxt = 1'b1;
            cmp_nxt = PCTL_REQ_I.data;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         xdata_r <= `LATCH_RESET;
         xvalid_r <= 1'b0;
         cmp_r <= `CFG_RESET;
      end else begin
         xdata_r <= xdata_nxt;
         xvalid_r <= xvalid_nxt;
         cmp_r <= cmp_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************

   // Pin drivers: a one in the direction register releases the pin
   assign PA_PIN_O = latch_a[3:0];
   assign PA_PIN_OE_N_O = cfg_a.dir_in[3:0];
   assign PB_PIN_O = latch_b;
   assign PB_PIN_OE_N_O = cfg_b.dir_in;
   assign PC_PIN_O = HAS_PORT_C ? latch_c : `LATCH_RESET;
   assign PC_PIN_OE_N_O = HAS_PORT_C ? cfg_c.dir_in : `CFG_RESET;

   // Configuration and status
   assign PA_CFG_O = cfg_a;
   assign PB_CFG_O = cfg_b;
   assign PC_CFG_O = cfg_c;
   assign WAKE_PENDING_O = pend_b;
   assign CMP_CTRL_O = cmp_r;
   assign SEL_O = sel_r;

   // Bus answers
   assign MEM_HIT_O = addr_hit(MEM_REQ_I.addr);
   assign MEM_RDATA_O = rdata_r;
   assign MEM_RVALID_O = rvalid_r;
   assign PCTL_RDATA_O = xdata_r;
   assign PCTL_RVALID_O = xvalid_r;

   // ****************************************
   // Checks
   // ****************************************

   // High only in the first cycle after reset
   always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         rst_seen_r <= 1'b1;
      end else begin
         rst_seen_r <= 1'b0;
      end
   end

   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (SYS_RST_I);

   sequence s_sel_pullup;
      sel_r == `SEL_PULLUP;
   endsequence

   sequence s_pullup_wr_c;
      CLK_EN_I && PCTL_REQ_I.wr && (PCTL_REQ_I.port == `PORT_CODE_C);
   endsequence

   chk_reset_values:
   assert property (rst_seen_r |-> (sel_r == `SEL_RESET) && (PB_CFG_O == `CFG_RESET_ALL)
                    && (PA_PIN_OE_N_O == 4'(`CFG_RESET)) && (CMP_CTRL_O == `CFG_RESET))
      else $error("Configuration not at reset value");

   chk_sel_write:
   assert property (CLK_EN_I && SEL_WR_I |=> SEL_O == $past(SEL_WDATA_I))
      else $error("Selector did not take the written value");

   chk_sel_persist:
   assert property (!(CLK_EN_I && SEL_WR_I) ##0 PCTL_REQ_I.wr |=> $stable(SEL_O))
      else $error("Selector changed without a selector write");

   chk_data_drive:
   assert property (data_wr_b |=> PB_PIN_O == $past(MEM_REQ_I.data))
      else $error("Port B latch did not take the data write");

   chk_dir_write:
   assert property (ctl_wr_b && (sel_r == `SEL_DIR) |=> PB_PIN_OE_N_O == $past(PCTL_REQ_I.data))
      else $error("Port B direction did not follow the control write");

   chk_latch_kept:
   assert property (ctl_wr_a && (sel_r == `SEL_DIR) && !data_wr_a |=> $stable(PA_PIN_O))
      else $error("Direction change disturbed the Port A latch");

   chk_read_pins:
   assert property (CLK_EN_I && MEM_REQ_I.rd && (MEM_REQ_I.addr == `ADDR_PORT_A)
                    |=> MEM_RVALID_O && (MEM_RDATA_O == {`PORT_A_PAD, $past(PA_PIN_I)}))
      else $error("Port A read did not return the pin levels");

   chk_reserved_ignored:
   assert property (CLK_EN_I && PCTL_REQ_I.wr && !names_reg(PCTL_REQ_I.port, sel_r)
                    |=> $stable(PA_CFG_O) && $stable(PB_CFG_O) && $stable(PC_CFG_O)
                        && $stable(CMP_CTRL_O) && !PCTL_RVALID_O)
      else $error("Control write with no named register changed state");

   chk_schmitt_a_absent:
   assert property (PA_CFG_O.schmitt_off == `CFG_RESET)
      else $error("Port A gained a Schmitt setting");

   chk_pend_exchange:
   assert property (ctl_wr_b && (sel_r == `SEL_WAKE_PEND)
                    |=> PCTL_RVALID_O && (PCTL_RDATA_O == $past(WAKE_PENDING_O)))
      else $error("Pending exchange returned the wrong word");

   chk_pullup_select:
   assert property (s_sel_pullup ##0 s_pullup_wr_c
                    |=> !HAS_PORT_C || (PC_CFG_O.pullup_off == $past(PCTL_REQ_I.data)))
      else $error("Pullup write via selector missed Port C");

endmodule
`default_nettype wire

// ---- src/gpio_defines.svh ----
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

// ****************************************
// File addresses of the pin data registers
// ****************************************
`define ADDR_PORT_A 8'h05
`define ADDR_PORT_B 8'h06
`define ADDR_PORT_C 8'h07

// ****************************************
// Selector codes
// ****************************************
`define SEL_CMP 8'h08
`define SEL_WAKE_PEND 8'h09
`define SEL_WAKE_EDGE 8'h0A
`define SEL_WAKE_EN 8'h0B
`define SEL_SCHMITT 8'h0C
`define SEL_LEVEL 8'h0D
`define SEL_PULLUP 8'h0E
`define SEL_DIR 8'h0F

// ****************************************
// Port codes and reset values
// ****************************************
`define PORT_CODE_A 2'h0
`define PORT_CODE_B 2'h1
`define PORT_CODE_C 2'h2
`define SEL_RESET 8'h0F
`define CFG_RESET 8'hFF
`define CFG_RESET_ALL 32'hFFFF_FFFF
`define LATCH_RESET 8'h00
`define PORT_A_PAD 4'h0
`endif

// ---- src/gpio_pkg.sv ----
package gpio_pkg;
   // Per-port configuration outputs
   typedef struct packed {
      logic [7:0] schmitt_off;
      logic [7:0] level_ttl;
      logic [7:0] pullup_off;
      logic [7:0] dir_in;
   } pin_cfg_t;
   // Data-memory request from the core
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } mem_req_t;
   // Port-control write from the core
   typedef struct packed {
      logic wr;
      logic [1:0] port;
      logic [7:0] data;
   } pctl_req_t;
endpackage

// ---- src/port_bank.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "gpio_defines.svh"
module port_bank
   import gpio_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic data_wr_i,
   input wire logic ctl_wr_i,
   input wire logic [7:0] sel_i,
   input wire logic [7:0] wdata_i,
   output pin_cfg_t cfg_o,
   output logic [7:0] latch_o
);
   // Pins that exist; writes set the bits above them to one
   localparam logic [7:0] PIN_MASK = 8'((16'h0001 << WIDTH) - 16'h0001);
   pin_cfg_t cfg_r, cfg_nxt;
   logic [7:0] latch_r, latch_nxt;

   function automatic logic [7:0] fold(input logic [7:0] d);
      return (d & PIN_MASK) | ~PIN_MASK;
   endfunction

   // Latch and control register updates
   always_comb begin
      cfg_nxt = cfg_r;
      latch_nxt = latch_r;
      if (data_wr_i) begin
         latch_nxt = fold(wdata_i);
      end
      if (ctl_wr_i) begin
         case (sel_i)
            `SEL_DIR: cfg_nxt.dir_in = fold(wdata_i);
            `SEL_PULLUP: cfg_nxt.pullup_off = fold(wdata_i);
            `SEL_LEVEL: cfg_nxt.level_ttl = fold(wdata_i);
            `SEL_SCHMITT: cfg_nxt.schmitt_off = fold(wdata_i);
            default: cfg_nxt = cfg_r;
         endcase
      end
   end

   // Register stage, configuration all ones and latch zero after reset
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_r <= `CFG_RESET_ALL;
         latch_r <= `LATCH_RESET;
      end else begin
         cfg_r <= cfg_nxt;
         latch_r <= latch_nxt;
      end
   end

   assign cfg_o = cfg_r;
   assign latch_o = latch_r;
endmodule
`default_nettype wire

// ---- src/wake_detect.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "gpio_defines.svh"
module wake_detect (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [7:0] pins_i,
   input wire logic ctl_wr_i,
   input wire logic [7:0] sel_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] pend_o
);
   logic [7:0] en_n_r, en_n_nxt, edge_r, edge_nxt;
   logic [7:0] pend_r, pend_nxt, prev_r, prev_nxt;
   logic [7:0] hit;

   // Edge detect, register writes, pending exchange
   always_comb begin
      en_n_nxt = en_n_r;
      edge_nxt = edge_r;
      pend_nxt = pend_r;
      prev_nxt = prev_r;
      hit = 8'h00;
      if (ce_i) begin
         prev_nxt = pins_i;
         // One in edge_r senses falling, zero rising
         hit = ~en_n_r & ((edge_r & prev_r & ~pins_i) | (~edge_r & ~prev_r & pins_i));
         if (ctl_wr_i) begin
            case (sel_i)
               `SEL_WAKE_EN: en_n_nxt = wdata_i;
               `SEL_WAKE_EDGE: edge_nxt = wdata_i;
               `SEL_WAKE_PEND: pend_nxt = wdata_i;
               default: pend_nxt = pend_r;
            endcase
         end
         pend_nxt = pend_nxt | hit; // Set wins over exchange
      end
   end

   // Register stage
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         en_n_r <= `CFG_RESET;
         edge_r <= `CFG_RESET;
         pend_r <= `CFG_RESET;
         prev_r <= `CFG_RESET;
      end else begin
         en_n_r <= en_n_nxt;
         edge_r <= edge_nxt;
         pend_r <= pend_nxt;
         prev_r <= prev_nxt;
      end
   end

   assign pend_o = pend_r;
endmodule
`default_nettype wire

// ---- bench/core_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module core_model
   import gpio_pkg::*;
(
   input wire logic clk_i,
   output mem_req_t mem_req_o,
   output pctl_req_t pctl_req_o,
   output logic sel_wr_o,
   output logic [7:0] sel_wdata_o
);
   // ****************************************
   // Core side of the port interfaces
   // ****************************************
   // Idle request lines from time zero
   initial begin
      mem_req_o = '0;
      pctl_req_o = '0;
      sel_wr_o = 1'b0;
      sel_wdata_o = 8'h00;
   end

   // Data-memory access, two idle slots ahead of every strobe
   task automatic mem_op(input logic rd, input logic wr, input logic [7:0] addr,
                         input logic [7:0] data);
      @(posedge clk_i);
      @(posedge clk_i);
      mem_req_o <= '{rd: rd, wr: wr, addr: addr, data: data};
      @(posedge clk_i);
      mem_req_o <= '0;
   endtask

   // Port-control write of the working byte
   task automatic pctl_op(input logic [1:0] port, input logic [7:0] data);
      @(posedge clk_i);
      pctl_req_o <= '{wr: 1'b1, port: port, data: data};
      @(posedge clk_i);
      pctl_req_o <= '0;
   endtask

   // Selector load, only through its own strobe
   task automatic sel_op(input logic [7:0] value);
      @(posedge clk_i);
      sel_wr_o <= 1'b1;
      sel_wdata_o <= value;
      @(posedge clk_i);
      sel_wr_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- bench/mode_indexed_gpio_ports_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "gpio_defines.svh"
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module mode_indexed_gpio_ports_bench
   import gpio_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   int errors = 0;
   int checks = 0;
   int cycles = 0;
   mem_req_t mem_req;
   pctl_req_t pctl_req;
   logic sel_wr;
   logic [7:0] sel_wdata, sel_q, mem_rdata, pctl_rdata, wake_pend, pb_out, pb_oe_n;
   logic [7:0] pc_out, pc_oe_n, cmp_ctrl, pb_low = 8'h00;
   logic [3:0] pa_out, pa_oe_n;
   logic mem_rvalid, pctl_rvalid, mem_hit;
   logic ce = 1'b1;
   logic cmp_res = 1'b0;
   wire logic [3:0] pa_pin;
   wire logic [7:0] pb_pin, pc_pin;
   pin_cfg_t pa_cfg, pb_cfg, pc_cfg;

   // ****************************************
   // Clock, reset, pins and watchdog
   // ****************************************
   always #4 clk = ~clk;
   // Driven pins show the latch, released pins the outside level
   assign pa_pin = (pa_oe_n & 4'h9) | (~pa_oe_n & pa_out);
   assign pb_pin = ((pb_oe_n & 8'hC3) | (~pb_oe_n & pb_out)) & ~pb_low;
   assign pc_pin = (pc_oe_n & 8'h3C) | (~pc_oe_n & pc_out);
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors++;
         give_verdict();
      end
   end

   core_model core (.clk_i(clk), .mem_req_o(mem_req), .pctl_req_o(pctl_req),
      .sel_wr_o(sel_wr), .sel_wdata_o(sel_wdata));
   gpio_ports uut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(ce), .MEM_REQ_I(mem_req),
      .MEM_HIT_O(mem_hit), .MEM_RDATA_O(mem_rdata), .MEM_RVALID_O(mem_rvalid),
      .PCTL_REQ_I(pctl_req), .PCTL_RDATA_O(pctl_rdata), .PCTL_RVALID_O(pctl_rvalid),
      .SEL_WR_I(sel_wr), .SEL_WDATA_I(sel_wdata), .SEL_O(sel_q),
      .PA_PIN_I(pa_pin), .PA_PIN_O(pa_out), .PA_PIN_OE_N_O(pa_oe_n),
      .PB_PIN_I(pb_pin), .PB_PIN_O(pb_out), .PB_PIN_OE_N_O(pb_oe_n),
      .PC_PIN_I(pc_pin), .PC_PIN_O(pc_out), .PC_PIN_OE_N_O(pc_oe_n),
      .PA_CFG_O(pa_cfg), .PB_CFG_O(pb_cfg), .PC_CFG_O(pc_cfg),
      .WAKE_PENDING_O(wake_pend), .CMP_RESULT_I(cmp_res), .CMP_CTRL_O(cmp_ctrl));

   // ****************************************
   // Scenarios
   // ****************************************
   // Port read answered one cycle later with the pin levels
   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      core.mem_op(1'b1, 1'b0, addr, 8'h00);
      #1;
      `CHECK(mem_rvalid, 1'b1)
      `CHECK(mem_rdata, exp)
   endtask

   // Reset state of selector and configuration
   task automatic t_reset();
      `CHECK(sel_q, `SEL_RESET)
      `CHECK({pa_cfg, pb_cfg, pc_cfg}, {3{`CFG_RESET_ALL}})
      `CHECK({pa_oe_n, pb_oe_n, pc_oe_n}, 20'hF_FFFF)
   endtask

   // Latches, direction and pin read-back
   task automatic t_latch();
      core.mem_op(1'b0, 1'b1, `ADDR_PORT_B, 8'h5A);
      #1;
      `CHECK({pb_out, pb_oe_n}, 16'h5AFF)
      rd_chk(`ADDR_PORT_B, 8'hC3);
      core.pctl_op(`PORT_CODE_B, 8'h00);
      #1;
      `CHECK({pb_oe_n, pb_cfg.dir_in}, 16'h0000)
      rd_chk(`ADDR_PORT_B, 8'h5A);
      @(posedge clk) pb_low <= 8'h02;
      rd_chk(`ADDR_PORT_B, 8'h58);
      @(posedge clk) pb_low <= 8'h00;
      core.mem_op(1'b0, 1'b1, `ADDR_PORT_A, 8'hFF);
      core.pctl_op(`PORT_CODE_A, 8'h00);
      #1;
      `CHECK({pa_out, pa_oe_n, pa_cfg.dir_in}, 16'hF0F0)
      rd_chk(`ADDR_PORT_A, 8'h0F);
      core.mem_op(1'b0, 1'b1, `ADDR_PORT_C, 8'h81);
      core.pctl_op(`PORT_CODE_C, 8'h00);
      rd_chk(`ADDR_PORT_C, 8'h81);
      core.mem_op(1'b1, 1'b0, 8'h04, 8'h00);
      #1;
      `CHECK(mem_rvalid, 1'b0)
   endtask

   // Selector decode of the control registers
   task automatic t_config();
      core.sel_op(`SEL_PULLUP);
      #1;
      `CHECK(sel_q, 8'h0E)
      core.pctl_op(`PORT_CODE_A, 8'h03);
      core.pctl_op(`PORT_CODE_B, 8'h3C);
      core.pctl_op(`PORT_CODE_C, 8'h00);
      #1;
      `CHECK({pa_cfg.pullup_off, pb_cfg.pullup_off, pc_cfg.pullup_off}, 24'hF3_3C00)
      core.sel_op(`SEL_LEVEL);
      core.pctl_op(`PORT_CODE_A, 8'h0A);
      core.pctl_op(`PORT_CODE_B, 8'h55);
      #1;
      `CHECK({pa_cfg.level_ttl, pb_cfg.level_ttl}, 16'hFA55)
      core.sel_op(`SEL_SCHMITT);
      core.pctl_op(`PORT_CODE_A, 8'h00);
      core.pctl_op(`PORT_CODE_C, 8'hA5);
      #1;
      `CHECK({pa_cfg.schmitt_off, pc_cfg.schmitt_off}, 16'hFFA5)
      core.sel_op(8'h05);
      core.pctl_op(`PORT_CODE_B, 8'h00);
      #1;
      `CHECK(pb_cfg, 32'hFF55_3C00)
      `CHECK(pctl_rvalid, 1'b0)
      core.sel_op(`SEL_WAKE_PEND);
      core.pctl_op(`PORT_CODE_B, 8'h00);
      #1;
      `CHECK({pctl_rvalid, pctl_rdata, wake_pend}, 17'h1_FF00)
   endtask

   // Wakeup capture, comparator exchange, clock enable and address hit
   task automatic t_wake();
      core.sel_op(`SEL_WAKE_EN);
      core.pctl_op(`PORT_CODE_B, 8'hFD);
      @(posedge clk) pb_low <= 8'h02;
      core.sel_op(`SEL_WAKE_PEND);
      #1;
      `CHECK(wake_pend, 8'h02)
      core.pctl_op(`PORT_CODE_B, 8'h00);
      #1;
      `CHECK({pctl_rvalid, pctl_rdata, wake_pend}, 17'h1_0200)
      core.sel_op(`SEL_WAKE_EDGE);
      core.pctl_op(`PORT_CODE_B, 8'h00);
      @(posedge clk) pb_low <= 8'h00;
      core.sel_op(`SEL_CMP);
      #1;
      `CHECK(wake_pend, 8'h02)
      core.pctl_op(`PORT_CODE_B, 8'h3C);
      #1;
      `CHECK({pctl_rvalid, pctl_rdata, cmp_ctrl}, 17'h1_FE3C)
      @(posedge clk) cmp_res <= 1'b1;
      core.pctl_op(`PORT_CODE_B, 8'h80);
      #1;
      `CHECK({pctl_rvalid, pctl_rdata, cmp_ctrl}, 17'h1_3D80)
      @(posedge clk) ce <= 1'b0;
      core.sel_op(`SEL_DIR);
      core.mem_op(1'b0, 1'b1, `ADDR_PORT_B, 8'hFF);
      #1;
      `CHECK({sel_q, pb_out, wake_pend}, {`SEL_CMP, 8'h5A, 8'h02})
      @(posedge clk) ce <= 1'b1;
      fork
         core.mem_op(1'b1, 1'b0, `ADDR_PORT_C, 8'h00);
         begin
            repeat (2) @(posedge clk);
            #1;
            `CHECK(mem_hit, 1'b1)
         end
      join
      #1;
      `CHECK({mem_hit, mem_rvalid, mem_rdata}, 10'h181)
   endtask

   // ****************************************
   // Verdict and main sequence
   // ****************************************
   task automatic give_verdict();
      if (errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      t_reset();
      t_latch();
      t_config();
      t_wake();
      give_verdict();
   end
endmodule
`default_nettype wire
